// [src/plc_mode_consts.svh]
// named constants of the operating mode sequencer: timing, offsets, fields, resets
// assumes a 40 MHz system clock and a 32-bit word-aligned register port with 8-bit addresses
`ifndef PLC_MODE_CONSTS_SVH
`define PLC_MODE_CONSTS_SVH

`define CLK_PERIOD_NS 25
`define NS_PER_MS 1000000
`define MS_CYCLES (`NS_PER_MS / `CLK_PERIOD_NS)
`define WATCHDOG_MS 100
`define CYCLE_MIN_MS 1
`define BLINK_MIN_S 3
`define BLINK_MIN_MS (`BLINK_MIN_S * 1000)
`define BLINK_HALF_MS 250
`define VISU_LIMIT_H 72
`define VISU_LIMIT_MS (`VISU_LIMIT_H * 3600 * 1000)
`define MAX_BREAKPOINTS 3
`define MAX_STEP_BREAKPOINTS 2

`define ADDR_CTRL 8'h00
`define ADDR_CMD 8'h04
`define ADDR_BREAK 8'h08
`define ADDR_CYCLE 8'h0C
`define ADDR_STATUS 8'h10

`define CTRL_RUN_SEL 0
`define CTRL_COLD_OK 1
`define CTRL_VISU 2
`define CTRL_SUBST 3
`define CTRL_W 4
`define CTRL_RESET 4'h0

`define CMD_STOP 0
`define CMD_OVERALL 1
`define CMD_RELOAD 2
`define CMD_STEP 3
`define CMD_RESUME 4

`define CYCLE_LIMIT_RESET 16'h0096

`define ST_MODE_LO 0
`define ST_FAULT 2
`define ST_WD_LOCK 3
`define ST_STEP_OK 4
`define ST_BPCNT_LO 5
`define ST_VISU_TERM 7
`define ST_CARD_MISS 8

`endif

// [src/plc_mode_pkg.sv]
// types of the operating mode sequencer: modes, run phases, carriers, state
// assumes plc_mode_consts.svh is on the include path
`include "plc_mode_consts.svh"

package plc_mode_pkg;

    typedef enum logic [1:0] {
        mode_stop,
        mode_startup,
        mode_run,
        mode_hold
    } mode_t;

    typedef enum logic [1:0] {
        ph_clear_out,
        ph_read,
        ph_exec,
        ph_write
    } phase_t;

    typedef struct packed {
        logic startup_done;
        logic startup_error;
        logic main_done;
        logic read_done;
        logic write_done;
        logic bp_hit;
    } prog_stat_t;

    typedef struct packed {
        logic startup_call;
        logic main_call;
        logic clear_input_image;
        logic clear_output_image;
        logic read_inputs;
        logic write_outputs;
        logic step_go;
        logic resume_go;
    } prog_cmd_t;

    typedef struct packed {
        mode_t mode;
        phase_t phase;
        logic [15:0] pre;
        logic [11:0] blink_left;
        logic [7:0] blink_ms;
        logic blink;
        logic [15:0] cyc_ms;
        logic [31:0] visu_ms;
        logic fault;
        logic wd_lock;
        logic visu_term;
        logic [`CTRL_W-1:0] ctrl;
        logic [2:0] bp_en;
        logic [15:0] cyc_limit;
        logic [31:0] rdata;
        prog_cmd_t cmd;
        logic output_disable;
        logic run_led;
        logic stop_led;
        logic sf_led;
        logic timers_freeze;
        logic analog_safe;
        logic subst_sel;
        logic decentral_scan;
        logic [1:0] card_sync;
    } st_t;

endpackage

// [src/plc_operating_mode_sequencer.sv]
// operating mode sequencer of a controller CPU: stop, start-up, run and hold
// assumes program side and register port on clk; card_present is an async pin
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps

module plc_operating_mode_sequencer #(
    parameter int MS_CYCLES = `MS_CYCLES,
    parameter int WATCHDOG_MS = `WATCHDOG_MS,
    parameter int BLINK_MIN_MS = `BLINK_MIN_MS,
    parameter int BLINK_HALF_MS = `BLINK_HALF_MS,
    parameter int VISU_LIMIT_MS = `VISU_LIMIT_MS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire plc_mode_pkg::prog_stat_t prog_stat,
    output plc_mode_pkg::prog_cmd_t prog_cmd,
    input wire logic card_present,
    output logic output_disable,
    output logic run_led,
    output logic stop_led,
    output logic system_fault_led,
    output logic timers_freeze,
    output logic analog_safe,
    output logic substitute_sel,
    output logic decentral_scan,
    output logic [1:0] mode
);

    plc_mode_pkg::st_t s_r;
    plc_mode_pkg::st_t s_nxt;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [1:0] bp_count(input logic [2:0] en);
        bp_count = {1'b0, en[0]} + {1'b0, en[1]} + {1'b0, en[2]};
    endfunction

    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    logic ms_tick;
    logic card_ok;
    logic step_ok;
    logic run_ok;
    logic wd_hit;
    logic cyc_hit;

    always_comb begin
        ms_tick = (s_r.pre == 16'(MS_CYCLES - 1));
        // second synchroniser stage only
        card_ok = s_r.card_sync[1];
        step_ok = (bp_count(s_r.bp_en) <= 2'(`MAX_STEP_BREAKPOINTS));
        run_ok = !s_r.wd_lock || s_r.ctrl[`CTRL_COLD_OK];
        wd_hit = (s_r.cyc_ms >= 16'(WATCHDOG_MS));
        cyc_hit = (s_r.cyc_ms >= s_r.cyc_limit);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd.clear_input_image = 1'b0;
        s_nxt.cmd.clear_output_image = 1'b0;
        s_nxt.cmd.step_go = 1'b0;
        s_nxt.cmd.resume_go = 1'b0;
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.card_sync = {s_r.card_sync[0], card_present};
        s_nxt.pre = ms_tick ? 16'h0000 : s_r.pre + 16'h0001;

        // blink timebase runs in every mode
        if (ms_tick) begin
            if (s_r.blink_ms >= 8'(BLINK_HALF_MS - 1)) begin
                s_nxt.blink_ms = 8'h00;
                s_nxt.blink = !s_r.blink;
            end else begin
                s_nxt.blink_ms = s_r.blink_ms + 8'h01;
            end
            if (s_r.blink_left != 12'h000) begin
                s_nxt.blink_left = s_r.blink_left - 12'h001;
            end
        end

        // ****************************************
        // register writes
        // ****************************************
        if (wr) begin
            case (addr)
                `ADDR_CTRL: begin
                    s_nxt.ctrl = wdata[`CTRL_W-1:0];
                end
                `ADDR_BREAK: begin
                    s_nxt.bp_en = wdata[`MAX_BREAKPOINTS-1:0];
                end
                `ADDR_CYCLE: begin
                    if (wdata[15:0] < 16'(`CYCLE_MIN_MS)) begin
                        s_nxt.cyc_limit = 16'(`CYCLE_MIN_MS);
                    end else begin
                        s_nxt.cyc_limit = wdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ****************************************
        // mode machine
        // ****************************************
        case (s_r.mode)
            plc_mode_pkg::mode_stop: begin
                s_nxt.cmd.startup_call = 1'b0;
                s_nxt.cmd.main_call = 1'b0;
                s_nxt.cmd.read_inputs = 1'b0;
                s_nxt.cmd.write_outputs = 1'b0;
                if (wr && addr == `ADDR_CMD && (wdata[`CMD_OVERALL] || wdata[`CMD_RELOAD])) begin
                    s_nxt.fault = 1'b0;
                    s_nxt.wd_lock = 1'b0;
                end else if (s_r.ctrl[`CTRL_RUN_SEL] && run_ok) begin
                    s_nxt.mode = plc_mode_pkg::mode_startup;
                    s_nxt.cmd.clear_input_image = 1'b1;
                    s_nxt.cmd.startup_call = 1'b1;
                    s_nxt.blink_left = 12'(BLINK_MIN_MS);
                end
            end
            plc_mode_pkg::mode_startup: begin
                s_nxt.cyc_ms = 16'h0000;
                if (wr && addr == `ADDR_CMD && wdata[`CMD_STOP]) begin
                    s_nxt.mode = plc_mode_pkg::mode_stop;
                    s_nxt.cmd.startup_call = 1'b0;
                end else if (prog_stat.startup_done) begin
                    s_nxt.cmd.startup_call = 1'b0;
                    if (prog_stat.startup_error) begin
                        s_nxt.mode = plc_mode_pkg::mode_stop;
                    end else begin
                        s_nxt.mode = plc_mode_pkg::mode_run;
                        s_nxt.phase = plc_mode_pkg::ph_clear_out;
                        s_nxt.fault = 1'b0;
                        s_nxt.wd_lock = 1'b0;
                    end
                end
            end
            plc_mode_pkg::mode_run: begin
                if (ms_tick) begin
                    s_nxt.cyc_ms = inc16(s_r.cyc_ms);
                end
                if (wd_hit || cyc_hit) begin
                    s_nxt.mode = plc_mode_pkg::mode_stop;
                    s_nxt.fault = 1'b1;
                    s_nxt.wd_lock = s_r.wd_lock || wd_hit;
                    s_nxt.cmd.main_call = 1'b0;
                    s_nxt.cmd.read_inputs = 1'b0;
                    s_nxt.cmd.write_outputs = 1'b0;
                end else if ((wr && addr == `ADDR_CMD && wdata[`CMD_STOP])
                             || !s_r.ctrl[`CTRL_RUN_SEL]) begin
                    s_nxt.mode = plc_mode_pkg::mode_stop;
                    s_nxt.cmd.main_call = 1'b0;
                    s_nxt.cmd.read_inputs = 1'b0;
                    s_nxt.cmd.write_outputs = 1'b0;
                end else if (s_r.phase == plc_mode_pkg::ph_exec && prog_stat.bp_hit
                             && s_r.bp_en != 3'b000) begin
                    s_nxt.mode = plc_mode_pkg::mode_hold;
                    s_nxt.cmd.main_call = 1'b0;
                end else begin
                    case (s_r.phase)
                        plc_mode_pkg::ph_clear_out: begin
                            s_nxt.cmd.clear_output_image = 1'b1;
                            s_nxt.cmd.read_inputs = 1'b1;
                            s_nxt.phase = plc_mode_pkg::ph_read;
                        end
                        plc_mode_pkg::ph_read: begin
                            if (prog_stat.read_done) begin
                                s_nxt.cmd.read_inputs = 1'b0;
                                s_nxt.cmd.main_call = 1'b1;
                                s_nxt.phase = plc_mode_pkg::ph_exec;
                            end
                        end
                        plc_mode_pkg::ph_exec: begin
                            if (prog_stat.main_done) begin
                                s_nxt.cmd.main_call = 1'b0;
                                s_nxt.cmd.write_outputs = 1'b1;
                                s_nxt.phase = plc_mode_pkg::ph_write;
                            end
                        end
                        plc_mode_pkg::ph_write: begin
                            if (prog_stat.write_done) begin
                                s_nxt.cmd.write_outputs = 1'b0;
                                s_nxt.cmd.read_inputs = 1'b1;
                                s_nxt.phase = plc_mode_pkg::ph_read;
                                s_nxt.cyc_ms = 16'h0000;
                            end
                        end
                        default: begin
                            s_nxt.phase = plc_mode_pkg::ph_read;
                        end
                    endcase
                end
            end
            plc_mode_pkg::mode_hold: begin
                if (wr && addr == `ADDR_CMD && wdata[`CMD_STOP]) begin
                    s_nxt.mode = plc_mode_pkg::mode_stop;
                end else if (wr && addr == `ADDR_CMD && wdata[`CMD_RESUME]) begin
                    s_nxt.mode = plc_mode_pkg::mode_run;
                    s_nxt.cmd.resume_go = 1'b1;
                    s_nxt.cmd.main_call = 1'b1;
                end else if (wr && addr == `ADDR_CMD && wdata[`CMD_STEP] && step_ok) begin
                    s_nxt.cmd.step_go = 1'b1;
                end
            end
            default: begin
                s_nxt.mode = plc_mode_pkg::mode_stop;
            end
        endcase

        // ****************************************
        // indicators and output gating
        // ****************************************
        // disable in every mode but run
        s_nxt.output_disable = (s_nxt.mode != plc_mode_pkg::mode_run);
        s_nxt.analog_safe = (s_nxt.mode != plc_mode_pkg::mode_run);
        s_nxt.subst_sel = s_nxt.ctrl[`CTRL_SUBST];
        s_nxt.timers_freeze = (s_nxt.mode == plc_mode_pkg::mode_hold);
        case (s_nxt.mode)
            plc_mode_pkg::mode_stop: begin
                s_nxt.run_led = (s_nxt.blink_left != 12'h000) && s_nxt.blink;
                s_nxt.stop_led = 1'b1;
            end
            plc_mode_pkg::mode_startup: begin
                s_nxt.run_led = s_nxt.blink;
                s_nxt.stop_led = 1'b1;
            end
            plc_mode_pkg::mode_run: begin
                s_nxt.run_led = (s_nxt.blink_left != 12'h000) ? s_nxt.blink : 1'b1;
                s_nxt.stop_led = 1'b0;
            end
            default: begin
                s_nxt.run_led = s_nxt.blink;
                s_nxt.stop_led = 1'b1;
            end
        endcase

        // ****************************************
        // visualization card supervision
        // ****************************************
        // missing card lights fault LED
        s_nxt.sf_led = s_r.ctrl[`CTRL_VISU] && !card_ok;
        if (!s_r.ctrl[`CTRL_VISU] || card_ok) begin
            s_nxt.visu_ms = 32'h0000_0000;
            s_nxt.visu_term = s_r.visu_term && s_r.ctrl[`CTRL_VISU];
        end else if (ms_tick) begin
            if (s_r.visu_ms >= 32'(VISU_LIMIT_MS - 1)) begin
                s_nxt.visu_term = 1'b1;
            end else begin
                s_nxt.visu_ms = s_r.visu_ms + 32'h0000_0001;
            end
        end

        // ****************************************
        // register reads, answered next cycle
        // ****************************************
        if (rd) begin
            case (addr)
                `ADDR_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
                `ADDR_BREAK: s_nxt.rdata = 32'(s_r.bp_en);
                `ADDR_CYCLE: s_nxt.rdata = 32'(s_r.cyc_limit);
                `ADDR_STATUS: begin
                    s_nxt.rdata[`ST_MODE_LO+:2] = s_r.mode;
                    s_nxt.rdata[`ST_FAULT] = s_r.fault;
                    s_nxt.rdata[`ST_WD_LOCK] = s_r.wd_lock;
                    s_nxt.rdata[`ST_STEP_OK] = step_ok;
                    s_nxt.rdata[`ST_BPCNT_LO+:2] = bp_count(s_r.bp_en);
                    s_nxt.rdata[`ST_VISU_TERM] = s_r.visu_term;
                    s_nxt.rdata[`ST_CARD_MISS] = !card_ok;
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.mode <= plc_mode_pkg::mode_stop;
            s_r.ctrl <= `CTRL_RESET;
            s_r.cyc_limit <= `CYCLE_LIMIT_RESET;
            s_r.output_disable <= 1'b1;
            s_r.analog_safe <= 1'b1;
            s_r.stop_led <= 1'b1;
            s_r.decentral_scan <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign prog_cmd = s_r.cmd;
    assign output_disable = s_r.output_disable;
    assign run_led = s_r.run_led;
    assign stop_led = s_r.stop_led;
    assign system_fault_led = s_r.sf_led;
    assign timers_freeze = s_r.timers_freeze;
    assign analog_safe = s_r.analog_safe;
    assign substitute_sel = s_r.subst_sel;
    assign decentral_scan = s_r.decentral_scan;
    assign mode = s_r.mode;

endmodule // plc_operating_mode_sequencer

// [verification/plc_mode_chk.sv]
// port checker of the operating mode sequencer, bound into the design
// assumes ce held high and BREAK writes seen on the register port
`timescale 1ns/1ps
`include "plc_mode_consts.svh"
module plc_mode_chk #(
    parameter int MS_CYCLES = 4,
    parameter int WATCHDOG_MS = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire plc_mode_pkg::prog_stat_t prog_stat,
    input wire plc_mode_pkg::prog_cmd_t prog_cmd,
    input wire logic card_present,
    input wire logic output_disable,
    input wire logic run_led,
    input wire logic stop_led,
    input wire logic system_fault_led,
    input wire logic timers_freeze,
    input wire logic analog_safe,
    input wire logic substitute_sel,
    input wire logic decentral_scan,
    input wire logic [1:0] mode
);
    // ****************************************
    // helper state
    // ****************************************
    // ms prescaler may be mid-count, so one ms and two cycles of slack
    localparam int RUN_MAX = WATCHDOG_MS * MS_CYCLES + MS_CYCLES + 2;
    logic [2:0] bp_en_r;
    logic [15:0] run_cnt_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            bp_en_r <= 3'h0;
            run_cnt_r <= 16'h0000;
        end else begin
            if (wr && addr == `ADDR_BREAK) begin
                bp_en_r <= wdata[2:0];
            end
            if (mode != 2'h2 || prog_stat.write_done) begin
                run_cnt_r <= 16'h0000;
            end else begin
                run_cnt_r <= run_cnt_r + 16'h0001;
            end
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_to_startup;
        mode == 2'h0 ##1 mode == 2'h1;
    endsequence
    sequence s_to_run;
        mode == 2'h1 ##1 mode == 2'h2;
    endsequence
    chk_disable_run: assert property (output_disable == (mode != 2'h2))
        else $error("output disable does not follow mode");
    chk_stop_idle: assert property (mode == 2'h0 |-> stop_led && !prog_cmd.main_call)
        else $error("stop mode runs program or stop led dark");
    chk_no_skip: assert property (mode == 2'h0 |=> mode inside {2'h0, 2'h1})
        else $error("stop left without start-up");
    chk_startup_entry: assert property (s_to_startup |-> prog_cmd.startup_call
        && prog_cmd.clear_input_image) else $error("start-up entry without call or clear");
    chk_run_entry: assert property (s_to_run |=> prog_cmd.clear_output_image
        && prog_cmd.read_inputs) else $error("run entry without image clear and read");
    chk_startup_ok: assert property (mode == 2'h1 && prog_stat.startup_done
        && !prog_stat.startup_error |=> mode == 2'h2) else $error("start-up done, no run");
    chk_startup_fail: assert property (mode == 2'h1 && prog_stat.startup_done
        && prog_stat.startup_error |=> mode == 2'h0) else $error("start-up error, no stop");
    chk_read_exec: assert property (mode == 2'h2 && prog_cmd.read_inputs
        && prog_stat.read_done |=> prog_cmd.main_call) else $error("main block not after read");
    chk_exec_write: assert property (mode == 2'h2 && prog_cmd.main_call
        && prog_stat.main_done |=> prog_cmd.write_outputs && !prog_cmd.main_call)
        else $error("write not after main block");
    chk_bp_hold: assert property (mode == 2'h2 && prog_cmd.main_call && prog_stat.bp_hit
        && bp_en_r != 3'h0 |=> mode == 2'h3 && !prog_cmd.main_call) else $error("no hold");
    chk_hold_outs: assert property (mode == 2'h3 |-> stop_led && timers_freeze
        && output_disable) else $error("hold outputs wrong");
    chk_step_go: assert property (wr && addr == `ADDR_CMD && wdata[`CMD_STEP]
        && mode == 2'h3 && $countones(bp_en_r) <= 2 |=> prog_cmd.step_go)
        else $error("step request not passed on");
    chk_step_only_hold: assert property (prog_cmd.step_go |-> $past(mode) == 2'h3)
        else $error("step pulse outside hold");
    chk_watchdog_bound: assert property (run_cnt_r <= RUN_MAX)
        else $error("run cycle overran the watchdog");
endmodule // plc_mode_chk

bind plc_operating_mode_sequencer plc_mode_chk #(
    .MS_CYCLES(MS_CYCLES),
    .WATCHDOG_MS(WATCHDOG_MS)
) u_chk (.clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .prog_stat(prog_stat), .prog_cmd(prog_cmd), .card_present(card_present),
    .output_disable(output_disable), .run_led(run_led), .stop_led(stop_led),
    .system_fault_led(system_fault_led), .timers_freeze(timers_freeze),
    .analog_safe(analog_safe), .substitute_sel(substitute_sel),
    .decentral_scan(decentral_scan), .mode(mode));

// [verification/prog_side_model.sv]
// program side model: start-up, read, main and write blocks answer after dly cycles
// assumes prog_cmd levels drop in the cycle after their done pulse is taken
`timescale 1ns/1ps
module prog_side_model (
    input wire logic clk,
    input wire logic reset,
    input wire plc_mode_pkg::prog_cmd_t prog_cmd,
    input wire logic [15:0] dly,
    input wire logic err,
    input wire logic bp_req,
    output plc_mode_pkg::prog_stat_t prog_stat
);
    logic [3:0] lv;
    logic [3:0] lv_r;
    logic [15:0] cnt_r;
    logic fired_r;
    logic fire;
    assign lv = {prog_cmd.startup_call, prog_cmd.read_inputs, prog_cmd.main_call,
        prog_cmd.write_outputs};
    // one pulse per level; a dly lowered mid-level answers at once, never hangs
    assign fire = (lv == lv_r) && (cnt_r >= dly) && !fired_r;
    always_ff @(posedge clk) begin
        lv_r <= lv;
        if (reset || lv != lv_r) begin
            cnt_r <= 16'h0000;
            fired_r <= 1'b0;
        end else begin
            if (cnt_r != 16'hFFFF) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            if (fire) begin
                fired_r <= 1'b1;
            end
        end
        prog_stat <= '0;
        prog_stat.startup_error <= err;
        if (!reset && fire) begin
            prog_stat.startup_done <= lv[3];
            prog_stat.read_done <= lv[2];
            prog_stat.main_done <= lv[1] & ~bp_req;
            prog_stat.bp_hit <= lv[1] & bp_req;
            prog_stat.write_done <= lv[0];
        end
    end
endmodule // prog_side_model

// [verification/tb_top.sv]
// register-port tests of the operating mode sequencer with a program side model
// assumes shortened counts: 4 cycles per ms, 5 ms watchdog, 20 ms blink, 10 ms visu
`timescale 1ns/1ps
`include "plc_mode_consts.svh"
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic card_present = 1'b1;
    logic [15:0] dly = 16'h0028;
    logic err = 1'b0;
    logic bp_req = 1'b0;
    logic [31:0] rdata;
    plc_mode_pkg::prog_stat_t prog_stat;
    plc_mode_pkg::prog_cmd_t prog_cmd;
    logic output_disable, run_led, stop_led, system_fault_led, timers_freeze;
    logic analog_safe, substitute_sel, decentral_scan;
    logic [1:0] mode;
    int n_mismatch = 0;
    int check_count = 0;

    plc_operating_mode_sequencer #(.MS_CYCLES(4), .WATCHDOG_MS(5), .BLINK_MIN_MS(20),
        .BLINK_HALF_MS(2), .VISU_LIMIT_MS(10)) u_dut (.clk(clk), .reset(reset), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .prog_stat(prog_stat),
        .prog_cmd(prog_cmd), .card_present(card_present), .output_disable(output_disable),
        .run_led(run_led), .stop_led(stop_led), .system_fault_led(system_fault_led),
        .timers_freeze(timers_freeze), .analog_safe(analog_safe),
        .substitute_sel(substitute_sel), .decentral_scan(decentral_scan), .mode(mode));
    prog_side_model u_model (.clk(clk), .reset(reset), .prog_cmd(prog_cmd), .dly(dly),
        .err(err), .bp_req(bp_req), .prog_stat(prog_stat));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic flag(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata & m, e);
    endtask
    // bounded poll; a timeout shows up as a mode mismatch
    task automatic wait_mode(input logic [1:0] m, input int n);
        int i;
        i = 0;
        while (mode !== m && i < n) begin
            @(posedge clk);
            #1;
            i++;
        end
        check({30'h0, mode}, {30'h0, m});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, tests
    // ****************************************
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 40000);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        flag(output_disable, 1'b1);
        flag(stop_led, 1'b1);
        flag(run_led, 1'b0);
        flag(decentral_scan, 1'b1);
        rd_chk(`ADDR_CYCLE, 32'h0000_FFFF, 32'h0000_0096);
        rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        // long start-up block must not trip the 5 ms watchdog
        wr_reg(`ADDR_CTRL, 32'h0000_0001);
        wait_mode(2'h1, 10);
        flag(output_disable, 1'b1);
        flag(stop_led, 1'b1);
        wait_mode(2'h2, 100);
        dly <= 16'h0002;
        flag(output_disable, 1'b0);
        flag(stop_led, 1'b0);
        flag(analog_safe, 1'b0);
        repeat (70) @(posedge clk);
        #1;
        flag(run_led, 1'b1);
        wr_reg(`ADDR_BREAK, 32'h0000_0007);
        rd_chk(`ADDR_STATUS, 32'h0000_007F, 32'h0000_0062);
        wr_reg(`ADDR_BREAK, 32'h0000_0001);
        bp_req <= 1'b1;
        wait_mode(2'h3, 60);
        bp_req <= 1'b0;
        flag(timers_freeze, 1'b1);
        flag(output_disable, 1'b1);
        rd_chk(`ADDR_STATUS, 32'h0000_007F, 32'h0000_0033);
        wr_reg(`ADDR_CMD, 32'h0000_0008);
        flag(mode == 2'h3, 1'b1);
        dly <= 16'h0028;
        wr_reg(`ADDR_CMD, 32'h0000_0010);
        wait_mode(2'h2, 5);
        wait_mode(2'h0, 200);
        flag(analog_safe, 1'b1);
        rd_chk(`ADDR_STATUS, 32'h0000_000F, 32'h0000_000C);
        wr_reg(`ADDR_CTRL, 32'h0000_0001);
        repeat (5) @(posedge clk);
        #1;
        flag(mode == 2'h0, 1'b1);
        wr_reg(`ADDR_CTRL, 32'h0000_0003);
        wait_mode(2'h2, 100);
        rd_chk(`ADDR_STATUS, 32'h0000_000C, 32'h0000_0000);
        // cycle monitor at 1 ms fires well before the watchdog
        wr_reg(`ADDR_CTRL, 32'h0000_0000);
        wait_mode(2'h0, 100);
        wr_reg(`ADDR_CYCLE, 32'h0000_0000);
        rd_chk(`ADDR_CYCLE, 32'h0000_FFFF, 32'h0000_0001);
        wr_reg(`ADDR_CTRL, 32'h0000_0001);
        wait_mode(2'h2, 100);
        wait_mode(2'h0, 40);
        rd_chk(`ADDR_STATUS, 32'h0000_000C, 32'h0000_0004);
        wr_reg(`ADDR_CTRL, 32'h0000_0000);
        err <= 1'b1;
        dly <= 16'h0002;
        wait_mode(2'h0, 100);
        wr_reg(`ADDR_CTRL, 32'h0000_0001);
        wait_mode(2'h1, 10);
        wait_mode(2'h0, 30);
        wr_reg(`ADDR_CTRL, 32'h0000_000C);
        wait_mode(2'h0, 100);
        err <= 1'b0;
        flag(substitute_sel, 1'b1);
        @(posedge clk);
        card_present <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        flag(system_fault_led, 1'b1);
        repeat (60) @(posedge clk);
        rd_chk(`ADDR_STATUS, 32'h0000_0184, 32'h0000_0184);
        wr_reg(`ADDR_CMD, 32'h0000_0002);
        rd_chk(`ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
        final_report();
    end
endmodule // tb_top
